// [logic/rps_reset_pin_sequencer.sv]
// Reset pin sequencer: drives the reset pin and holds the internal reset
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Reset pin active low, two-way, shared.
// - Drive pin low 512 cycles after the last source cycle, release.
// - Internal reset held for 768-cycle sequence.
// - Pin held low outside extends internal reset.
// - NVM logic supply low starts reset.
// - Each sensor supply has its own detector.
// - Internal pull-up keeps released pin high.
module rps_reset_pin_sequencer (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic padSupplyLowN,
    input wire logic nvmLogicSupplyLowN,
    input wire logic internalResetReq,
    input wire logic resetPinIn,
    input wire logic sensorSupplyOneLowN,
    input wire logic sensorSupplyTwoLowN,
    output logic resetPinOut,
    output logic resetPinOe,
    output logic resetPinPullUpEn,
    output logic internalResetN,
    output logic sensorSupplyOneLowDetect,
    output logic sensorSupplyTwoLowDetect
);
    // Pins and supply monitors are asynchronous: two flops each
    logic [rps_pkg::SYNC_W-1:0] syncA_q;
    logic [rps_pkg::SYNC_W-1:0] syncA_d;
    logic [rps_pkg::SYNC_W-1:0] syncB_q;
    logic [rps_pkg::SYNC_W-1:0] syncB_d;
    logic [rps_pkg::SYNC_W-1:0] syncIn;

    assign syncIn = {sensorSupplyTwoLowN, sensorSupplyOneLowN, resetPinIn,
                     nvmLogicSupplyLowN, padSupplyLowN};

    // Only the second stage is read by logic; the first may be metastable
    always_comb begin
        syncA_d = syncIn;
        syncB_d = syncA_q;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            syncA_q <= rps_pkg::SYNC_IDLE;
            syncB_q <= rps_pkg::SYNC_IDLE;
        end else begin
            syncA_q <= syncA_d;
            syncB_q <= syncB_d;
        end
    end

    logic padLow;
    logic nvmLow;
    logic pinLow;
    logic source;

    assign padLow = ~syncB_q[rps_pkg::SYNC_PAD];
    assign nvmLow = ~syncB_q[rps_pkg::SYNC_NVM];
    // Pin level is seen two edges late, so own release shows up in WAIT only
    assign pinLow = ~syncB_q[rps_pkg::SYNC_PIN];
    // Own drive of the pin is not a new source, else it would retrigger forever
    assign source = padLow | nvmLow | internalResetReq;

    rps_pkg::rps_state_t state_q, state_d;
    logic [rps_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic drive_q, drive_d;
    logic intRstN_q, intRstN_d;
    logic lvd1_q, lvd1_d;
    logic lvd2_q, lvd2_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        drive_d = drive_q;
        intRstN_d = intRstN_q;
        case (state_q)
            rps_pkg::RPS_IDLE: begin
                if (source) begin
                    state_d = rps_pkg::RPS_DRIVE;
                    cnt_d = rps_pkg::CNT_ZERO;
                    drive_d = 1'b1;
                    intRstN_d = 1'b0;
                end else if (pinLow) begin
                    // External reset: known start-up state while low
                    state_d = rps_pkg::RPS_HOLD;
                    intRstN_d = 1'b0;
                end
            end
            rps_pkg::RPS_DRIVE: begin
                cnt_d = cnt_q + rps_pkg::CNT_ONE;
                if (source) begin
                    cnt_d = rps_pkg::CNT_ZERO;
                end else if (cnt_q == rps_pkg::PIN_DRIVE_LAST) begin
                    drive_d = 1'b0;
                    state_d = rps_pkg::RPS_WAIT;
                end
            end
            rps_pkg::RPS_WAIT: begin
                cnt_d = cnt_q + rps_pkg::CNT_ONE;
                if (source) begin
                    state_d = rps_pkg::RPS_DRIVE;
                    cnt_d = rps_pkg::CNT_ZERO;
                    drive_d = 1'b1;
                end else if (cnt_q == rps_pkg::SEQ_LAST) begin
                    state_d = rps_pkg::RPS_HOLD;
                end
            end
            rps_pkg::RPS_HOLD: begin
                if (source) begin
                    state_d = rps_pkg::RPS_DRIVE;
                    cnt_d = rps_pkg::CNT_ZERO;
                    drive_d = 1'b1;
                end else if (!pinLow) begin
                    intRstN_d = 1'b1;
                    state_d = rps_pkg::RPS_IDLE;
                end
            end
            default: begin
                state_d = rps_pkg::RPS_IDLE;
            end
        endcase
    end

    // Power-on reset counts as a source: start driving at once
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= rps_pkg::RPS_DRIVE;
            cnt_q <= rps_pkg::CNT_ZERO;
            drive_q <= 1'b1;
            intRstN_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            drive_q <= drive_d;
            intRstN_q <= intRstN_d;
        end
    end

    // Sensor domains: two independent detectors, no shared state
    always_comb begin
        lvd1_d = ~syncB_q[rps_pkg::SYNC_S1];
        lvd2_d = ~syncB_q[rps_pkg::SYNC_S2];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lvd1_q <= 1'b0;
            lvd2_q <= 1'b0;
        end else begin
            lvd1_q <= lvd1_d;
            lvd2_q <= lvd2_d;
        end
    end

    // Pin level and pull-up: registered so every output leaves a flop
    logic pull_q;
    logic pull_d;
    logic pinLevel_q;
    logic pinLevel_d;

    always_comb begin
        // Pin is only ever pulled low; a released pin rises by the pull-up
        pinLevel_d = 1'b0;
        pull_d = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pinLevel_q <= 1'b0;
            pull_q <= 1'b1;
        end else begin
            pinLevel_q <= pinLevel_d;
            pull_q <= pull_d;
        end
    end

    // Limitation: external low alone never drives the pin, it only holds
    // the internal reset; otherwise the block would latch its own drive.
    assign resetPinOut = pinLevel_q;
    assign resetPinOe = drive_q;
    assign resetPinPullUpEn = pull_q;
    assign internalResetN = intRstN_q;
    assign sensorSupplyOneLowDetect = lvd1_q;
    assign sensorSupplyTwoLowDetect = lvd2_q;
endmodule : rps_reset_pin_sequencer

`default_nettype wire

// [logic/rps_pkg.sv]
// Constants for the reset pin sequencer
package rps_pkg;
    localparam int unsigned PIN_DRIVE_CYCLES = 512;
    localparam int unsigned SEQ_CYCLES = 768;
    localparam int unsigned CNT_W = 10;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [CNT_W-1:0] PIN_DRIVE_LAST = 10'h1FF;
    localparam logic [CNT_W-1:0] SEQ_LAST = 10'h2FF;
    // Synchroniser lanes: bit positions of each asynchronous input
    localparam int unsigned SYNC_W = 5;
    localparam int unsigned SYNC_PAD = 0;
    localparam int unsigned SYNC_NVM = 1;
    localparam int unsigned SYNC_PIN = 2;
    localparam int unsigned SYNC_S1 = 3;
    localparam int unsigned SYNC_S2 = 4;
    // All inputs idle high: no false source straight after reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h1F;
    typedef enum logic [1:0] {
        RPS_IDLE,
        RPS_DRIVE,
        RPS_WAIT,
        RPS_HOLD
    } rps_state_t;
endpackage : rps_pkg

// [bench/rps_reset_pin_sequencer_properties.sv]
// Checker for the reset pin sequencer ports
`timescale 1ns/1ps
`default_nettype none
module rps_checker (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic internalResetReq,
    input wire logic padSupplyLowN,
    input wire logic nvmLogicSupplyLowN,
    input wire logic resetPinIn,
    input wire logic sensorSupplyOneLowN,
    input wire logic sensorSupplyTwoLowN,
    input wire logic sensorSupplyTwoLowDetect,
    input wire logic resetPinOut,
    input wire logic resetPinOe,
    input wire logic resetPinPullUpEn,
    input wire logic internalResetN,
    input wire logic sensorSupplyOneLowDetect
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [9:0] oeCnt_q;
    logic [1:0] padSeen_q, nvmSeen_q;
    logic srcHit;
    // Supply sources reach the sequencer two edges late
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            padSeen_q <= 2'h3;
            nvmSeen_q <= 2'h3;
        end else begin
            padSeen_q <= {padSeen_q[0], padSupplyLowN};
            nvmSeen_q <= {nvmSeen_q[0], nvmLogicSupplyLowN};
        end
    end
    assign srcHit = internalResetReq | ~padSeen_q[1] | ~nvmSeen_q[1];
    // Drive length counts from the last source cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) oeCnt_q <= 10'h000;
        else oeCnt_q <= (!resetPinOe || srcHit) ? 10'h000 : oeCnt_q + 10'h001;
    end
    pin_low_a: assert property (resetPinOut == 1'h0) else $error("pin drive high");
    pullup_on_a: assert property (resetPinPullUpEn) else $error("pull-up off");
    drive_len_a: assert property ($fell(resetPinOe) |-> oeCnt_q == 10'h200)
        else $error("drive length");
    seq_hold_a: assert property ($fell(resetPinOe) |-> ##255 !internalResetN)
        else $error("early release");
    ext_hold_a: assert property (!resetPinIn [*5] |-> !internalResetN)
        else $error("pin low ignored");
    pin_gate_a: assert property ($rose(internalResetN) |-> $past(resetPinIn, 3))
        else $error("release while pin low");
    req_src_a: assert property (internalResetReq |-> ##[1:2] resetPinOe)
        else $error("request not driven");
    sense_one_a: assert property ($stable(sensorSupplyOneLowN) [*5] |->
        sensorSupplyOneLowDetect == !sensorSupplyOneLowN) else $error("detect wrong");
    sense_two_a: assert property ($stable(sensorSupplyTwoLowN) [*5] |->
        sensorSupplyTwoLowDetect == !sensorSupplyTwoLowN) else $error("detect two wrong");
    cover property ($fell(resetPinOe));
    cover property ($rose(internalResetN));
    cover property (!resetPinIn && !resetPinOe);
endmodule : rps_checker
bind rps_reset_pin_sequencer rps_checker chk (.*);
`default_nettype wire

// [bench/rps_board_model.sv]
// Board circuitry sharing the reset line
`timescale 1ns/1ps
`default_nettype none
module rps_board_model (
    input wire logic resetPinOut,
    input wire logic resetPinOe,
    input wire logic resetPinPullUpEn,
    input wire logic buttonHeld,
    output logic resetPinIn
);
    // Wired-AND line; nobody pulling leaves the pull-up level
    assign resetPinIn = (resetPinOe && !resetPinOut) || buttonHeld ? 1'h0 : resetPinPullUpEn;
endmodule : rps_board_model
`default_nettype wire

// [bench/test_reset_pin_sequencer.sv]
// Testbench for the reset pin sequencer
`timescale 1ns/1ps
`default_nettype none
module test_reset_pin_sequencer;
    logic ref_clk = 1'h0, resetn = 1'h0, padSupplyLowN = 1'h1, nvmLogicSupplyLowN = 1'h1;
    logic internalResetReq = 1'h0, sensorSupplyOneLowN = 1'h1, sensorSupplyTwoLowN = 1'h1;
    logic buttonHeld = 1'h0, resetPinIn, resetPinOut, resetPinOe, resetPinPullUpEn;
    logic internalResetN, sensorSupplyOneLowDetect, sensorSupplyTwoLowDetect;
    int fail_count = 0, n_tests = 0;
    rps_reset_pin_sequencer uut (.*);
    rps_board_model board (.*);
    initial forever #2 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic report_and_stop;
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic t_power_on;
        cyc(511);
        chk("oe", 1'h1, resetPinOe);
        chk("pinOut", 1'h0, resetPinOut);
        chk("pullUp", 1'h1, resetPinPullUpEn);
        cyc(1);
        chk("oe", 1'h0, resetPinOe);
        cyc(250);
        chk("intN", 1'h0, internalResetN);
        cyc(30);
        chk("intN", 1'h1, internalResetN);
    endtask : t_power_on
    task automatic t_source(input int which);
        internalResetReq = (which == 0);
        padSupplyLowN = (which != 1);
        nvmLogicSupplyLowN = (which != 2);
        cyc(2);
        {internalResetReq, padSupplyLowN, nvmLogicSupplyLowN} = 3'h3;
        cyc(4);
        chk("oe", 1'h1, resetPinOe);
        cyc(1000);
        chk("intN", 1'h1, internalResetN);
    endtask : t_source
    task automatic t_external;
        {internalResetReq, buttonHeld} = 2'h3;
        cyc(1);
        internalResetReq = 1'h0;
        cyc(1100);
        chk("intN", 1'h0, internalResetN);
        buttonHeld = 1'h0;
        cyc(6);
        chk("intN", 1'h1, internalResetN);
    endtask : t_external
    task automatic t_ext_idle;
        buttonHeld = 1'h1;
        cyc(5);
        chk("intN", 1'h0, internalResetN);
        chk("oe", 1'h0, resetPinOe);
        buttonHeld = 1'h0;
        cyc(5);
        chk("intN", 1'h1, internalResetN);
    endtask : t_ext_idle
    task automatic t_mid_reset;
        resetn = 1'h0;
        cyc(2);
        chk("oe", 1'h1, resetPinOe);
        chk("intN", 1'h0, internalResetN);
        resetn = 1'h1;
        t_power_on();
    endtask : t_mid_reset
    task automatic t_sensor;
        sensorSupplyOneLowN = 1'h0;
        cyc(5);
        chk("det1", 1'h1, sensorSupplyOneLowDetect);
        chk("det2", 1'h0, sensorSupplyTwoLowDetect);
        {sensorSupplyOneLowN, sensorSupplyTwoLowN} = 2'h2;
        cyc(5);
        chk("det1", 1'h0, sensorSupplyOneLowDetect);
        chk("det2", 1'h1, sensorSupplyTwoLowDetect);
    endtask : t_sensor
    initial begin
        cyc(16);
        resetn = 1'h1;
        t_power_on();
        for (int i = 0; i < 3; i++) t_source(i);
        t_external();
        t_ext_idle();
        t_mid_reset();
        t_sensor();
        report_and_stop();
    end
    initial begin
        #40000;
        fail_count++;
        report_and_stop();
    end
endmodule : test_reset_pin_sequencer
`default_nettype wire
